//--- design/power_save_sequencer.sv
// Power-save sequencer: protected control register, HALT and standby state machine.
// Assumes an AXI4-Lite master, a core that pulses halt_exec and an interrupt
// controller on aclk; nmi_pin is asynchronous.
`timescale 1ns/1ps
module power_save_sequencer
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Register bus
  input  wire axil_req_t axil_req,
  output axil_rsp_t      axil_rsp,
  // Core and interrupt side
  input  wire logic      halt_exec,
  input  wire logic      nmi_pin,
  input  wire irq_ctx_t  irq_ctx,
  // Clock control and wake report
  output clk_ctl_t       clk_ctl,
  output logic           irq_accept_block,
  output wake_evt_t      wake_evt
);

`include "pss_cfg.svh"

  // One-hot register select from a bus address
  function automatic logic [3:0] reg_sel(input logic [31:0] addr);
    logic [`PSS_ADDR_W-1:0] a;
    a = addr[`PSS_ADDR_W-1:0];
    reg_sel = {a == `PSS_OFF_STAT, a == `PSS_OFF_CTL, a == `PSS_OFF_CMD, a == `PSS_OFF_MODE};
  endfunction

  // Wake outcome {ack, branch, next_instr}; lower priority than the handler in service stays pending
  function automatic logic [2:0] wake_decide(input logic from_nmi, input irq_ctx_t c);
    logic higher;
    higher = 1'b0;
    if (from_nmi)
      higher = ~c.nmi_insvc;
    else
      higher = ~c.nmi_insvc & (~c.insvc | (c.mi_prio < c.insvc_prio));
    wake_decide = {higher, higher & (from_nmi | c.int_en), higher & ~(from_nmi | c.int_en)};
  endfunction

  // Bus slave state
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // Registers and control state
  logic [7:0]  mode_q;
  logic [7:0]  ctl_q;
  logic        perr_q;
  pwr_state_t  state_q;
  pwr_state_t  state_d;
  clk_ctl_t    clk_q;
  wake_evt_t   wake_q;

  // NMI pin synchroniser and filtered level
  logic        nmi_s1_q;
  logic        nmi_s2_q;
  logic        nmi_s3_q;
  logic        nmi_lvl_q;

  // Submodule results
  logic        armed;
  logic        ctl_ok;
  logic        ctl_fail;

  // Handshakes and write decode
  wire         aw_hs     = axil_req.awvalid & awready_q;
  wire         w_hs      = axil_req.wvalid & wready_q;
  wire         b_hs      = bvalid_q & axil_req.bready;
  wire         ar_hs     = axil_req.arvalid & arready_q;
  wire         r_hs      = rvalid_q & axil_req.rready;
  wire         do_write  = ~awready_q & ~wready_q & ~bvalid_q;
  wire [3:0]   wsel      = reg_sel(awaddr_q);
  wire [3:0]   rsel      = reg_sel(axil_req.araddr);
  wire         wr_fire   = do_write & wstrb_q[0];
  wire         wr_mode   = wr_fire & wsel[0];
  wire         wr_stat   = wr_fire & wsel[3];
  wire [7:0]   wbyte     = wdata_q[7:0];

  // Wake sources; an NMI counts on a rising edge of the filtered level
  wire         nmi_edge  = nmi_lvl_q == 1'b0 && nmi_s2_q == nmi_s3_q && nmi_s3_q == 1'b1;
  wire         halt_wake = nmi_edge | irq_ctx.mi_req;
  wire         sb_nmi    = nmi_edge & ~ctl_q[`PSS_CTL_NMI_DIS];
  wire         sb_mi     = irq_ctx.mi_req & ~ctl_q[`PSS_CTL_MI_DIS];
  wire         sb_wake   = sb_nmi | sb_mi;
  wire         in_halt   = state_q == ST_HALT;
  wire         in_sb     = state_q == ST_STANDBY;
  wire         waking    = (in_halt & halt_wake) | (in_sb & sb_wake);
  wire         wake_nmi  = in_halt ? nmi_edge : sb_nmi;
  wire [2:0]   decision  = wake_decide(wake_nmi, irq_ctx);
  wire         stb_go    = ctl_ok & wbyte[`PSS_CTL_STB];
  wire         is_stop   = mode_q[`PSS_MODE_STOP];

  // Status word
  wire [7:0]   stat_word = {2'b00, nmi_lvl_q, armed, perr_q, state_q};

  // Read mux; the control register reads directly with no unlock
  wire [7:0]   rd_byte   = rsel[0] ? mode_q :
                           rsel[2] ? ctl_q :
                           rsel[3] ? stat_word : 8'h00;
  wire         rd_hit    = |rsel;
  wire         wr_hit    = |wsel;

  // Unlock tracking for the protected control register
  protect_unlock u_unlock
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_fire   (wr_fire),
    .wr_is_cmd (wsel[1]),
    .wr_is_ctl (wsel[2]),
    .abort     (halt_exec),
    .armed_q   (armed),
    .ctl_ok    (ctl_ok),
    .ctl_fail  (ctl_fail)
  );

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        awaddr_q  <= axil_req.awaddr;
      end
      else if (b_hs)
        awready_q <= 1'b1;
      if (w_hs)
      begin
        wready_q <= 1'b0;
        wdata_q  <= axil_req.wdata;
        wstrb_q  <= axil_req.wstrb;
      end
      else if (b_hs)
        wready_q <= 1'b1;
    end
  end

  // Write response follows both channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PSS_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
    end
    else if (b_hs)
      bvalid_q <= 1'b0;
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `PSS_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_byte};
      rresp_q   <= rd_hit ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
    end
    else if (r_hs)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Mode select takes a plain write; it must precede the protected store
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= `PSS_MODE_RST;
    else if (wr_mode)
      mode_q <= wbyte & `PSS_MODE_WMASK;
  end

  // Control register: protected write, standby bit cleared by hardware on release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_q <= `PSS_CTL_RST;
    else if (ctl_ok && state_q == ST_RUN)
      ctl_q <= wbyte & `PSS_CTL_WMASK;
    else if (in_sb && sb_wake)
      ctl_q[`PSS_CTL_STB] <= 1'b0;
  end

  // Sticky protection error; a new failure wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      perr_q <= 1'b0;
    else if (ctl_fail)
      perr_q <= 1'b1;
    else if (wr_stat && wbyte[`PSS_STAT_PERR])
      perr_q <= 1'b0;
  end

  // NMI pin: three flops, level accepted once the last two agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_s1_q  <= 1'b0;
      nmi_s2_q  <= 1'b0;
      nmi_s3_q  <= 1'b0;
      nmi_lvl_q <= 1'b0;
    end
    else
    begin
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      if (nmi_s2_q == nmi_s3_q)
        nmi_lvl_q <= nmi_s3_q;
    end
  end

  // Power state transitions
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
        if (halt_exec)
          state_d = ST_HALT;
        else if (stb_go)
          state_d = ST_STANDBY;
      ST_HALT:
        if (halt_wake)
          state_d = ST_RUN;
      ST_STANDBY:
        if (sb_wake)
          state_d = ST_RUN;
    endcase
  end

  // Reset pin release returns to the ordinary reset state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_RUN;
    else
      state_q <= state_d;
  end

  // Clock gating; nothing else is touched, so core and RAM contents stay as they were
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clk_q <= '{osc_run: 1'b1, periph_clk_en: 1'b1, cpu_clk_en: 1'b1};
    else
    begin
      clk_q.cpu_clk_en    <= state_d == ST_RUN;
      clk_q.periph_clk_en <= state_d != ST_STANDBY;
      clk_q.osc_run       <= !(state_d == ST_STANDBY && is_stop);
    end
  end

  // Wake report pulses, one cycle each
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_q <= '0;
    else
    begin
      wake_q.ack        <= waking & decision[2];
      wake_q.branch     <= waking & decision[1];
      wake_q.next_instr <= waking & decision[0];
      wake_q.hold       <= waking & ~decision[2];
      wake_q.from_nmi   <= waking & wake_nmi;
    end
  end

  // Outputs, all from flops
  assign axil_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                      arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
  assign clk_ctl          = clk_q;
  assign irq_accept_block = armed;
  assign wake_evt         = wake_q;

endmodule

//--- design/pss_cfg.svh
// Register map, field positions, reset values and codes of the power-save sequencer.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one aligned word.
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// Decoded address width (low byte of the bus address)
`define PSS_ADDR_W        8

// Register byte offsets
`define PSS_OFF_MODE      8'h00
`define PSS_OFF_CMD       8'h04
`define PSS_OFF_CTL       8'h08
`define PSS_OFF_STAT      8'h0c

// Control register fields
`define PSS_CTL_NMI_DIS   5
`define PSS_CTL_MI_DIS    4
`define PSS_CTL_STB       1
`define PSS_CTL_WMASK     8'h32
`define PSS_CTL_RST       8'h00

// Mode select register: bit 0 picks standby flavour
`define PSS_MODE_STOP     0
`define PSS_MODE_WMASK    8'h01
`define PSS_MODE_RST      8'h00

// Status register fields
`define PSS_STAT_ST_LSB   0
`define PSS_STAT_PERR     3
`define PSS_STAT_ARMED    4
`define PSS_STAT_NMI      5

// Bus responses
`define PSS_RESP_OKAY     2'b00
`define PSS_RESP_SLVERR   2'b10

`endif

//--- design/pss_pkg.sv
// Types shared by the power-save sequencer modules.
// Assumes a 32-bit AXI4-Lite bus and a 3-bit interrupt priority (0 is highest).
package pss_pkg;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  // Interrupt context from the interrupt controller and core
  typedef struct packed {
    logic       mi_req;      // Unmasked maskable request, level
    logic [2:0] mi_prio;     // Its priority, 0 highest
    logic       insvc;       // A maskable handler is in service
    logic [2:0] insvc_prio;  // Priority of that handler
    logic       nmi_insvc;   // NMI handler in service
    logic       int_en;      // Core interrupt enable (EI)
  } irq_ctx_t;

  // Clock control outputs
  typedef struct packed {
    logic osc_run;
    logic periph_clk_en;
    logic cpu_clk_en;
  } clk_ctl_t;

  // Wake-up report, one-cycle pulses
  typedef struct packed {
    logic ack;        // Request acknowledged
    logic branch;     // Core branches to handler
    logic next_instr; // Core continues with next instruction
    logic hold;       // Request left pending
    logic from_nmi;   // Wake source was the NMI
  } wake_evt_t;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_HALT    = 3'b010,
    ST_STANDBY = 3'b100
  } pwr_state_t;

endpackage

//--- design/protect_unlock.sv
// Write-protect unlock tracker for the power-save control register.
// Assumes one-cycle write strobes from the bus slave on the same clock.
`timescale 1ns/1ps
module protect_unlock
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Write events
  input  wire logic wr_fire,
  input  wire logic wr_is_cmd,
  input  wire logic wr_is_ctl,
  input  wire logic abort,
  // Results
  output logic      armed_q,
  output logic      ctl_ok,
  output logic      ctl_fail
);

  // A protected control write is honoured only straight after the command store
  assign ctl_ok   = wr_fire & wr_is_ctl & armed_q;
  assign ctl_fail = wr_fire & wr_is_ctl & ~armed_q;

  // Any write other than the command store consumes the unlock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed_q <= 1'b0;
    else if (abort)
      armed_q <= 1'b0;
    else if (wr_fire)
      armed_q <= wr_is_cmd;
  end

endmodule

//--- tb/power_save_sequencer_asserts.sv
// Concurrent checks on the power-save sequencer top-level ports.
// Assumes the design's package and a single aclk domain with aresetn.
`timescale 1ns/1ps
module power_save_sequencer_asserts
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic      aclk,
  input wire logic      aresetn,
  // Register bus
  input wire axil_req_t axil_req,
  input wire axil_rsp_t axil_rsp,
  // Core and interrupt side
  input wire logic      halt_exec,
  input wire logic      nmi_pin,
  input wire irq_ctx_t  irq_ctx,
  // Clock control and wake report
  input wire clk_ctl_t  clk_ctl,
  input wire logic      irq_accept_block,
  input wire wake_evt_t wake_evt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Halt seen as core clock off with peripherals running
  wire in_halt = !clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en;
  wire wr_go   = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  wire lower   = irq_ctx.nmi_insvc || (irq_ctx.insvc && irq_ctx.mi_prio >= irq_ctx.insvc_prio);

  a_halt_entry: assert property (halt_exec && clk_ctl == 3'b111 && !wr_go |=> clk_ctl == 3'b110)
    else $error("halt entry clocks wrong");
  a_halt_osc: assert property (in_halt |-> clk_ctl.osc_run)
    else $error("oscillator stopped in halt");
  a_mi_wakes: assert property (in_halt && irq_ctx.mi_req
    |=> clk_ctl.cpu_clk_en && (wake_evt.ack || wake_evt.hold))
    else $error("maskable request did not wake halt");
  a_lower_held: assert property (in_halt && irq_ctx.mi_req && lower |=> wake_evt.hold && !wake_evt.ack)
    else $error("lower priority request not held");
  a_higher_acked: assert property (in_halt && irq_ctx.mi_req && !lower
    |=> wake_evt.ack && wake_evt.branch == $past(irq_ctx.int_en))
    else $error("higher priority request not acknowledged");
  a_ack_excl: assert property (wake_evt.ack |-> !wake_evt.hold && wake_evt.branch != wake_evt.next_instr)
    else $error("wake outcome inconsistent");
  a_nmi_branch: assert property (wake_evt.ack && wake_evt.from_nmi |-> wake_evt.branch)
    else $error("acknowledged nmi did not branch");
  // Store lands one cycle after the handshake, so the block shows a cycle later
  a_cmd_blocks: assert property (wr_go && axil_req.awaddr[7:0] == 8'h04 && axil_req.wstrb[0]
    |-> ##2 irq_accept_block)
    else $error("command store did not block interrupts");
  a_read_direct: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read not answered");
  a_reset_run: assert property (disable iff (1'b0) !aresetn |=> clk_ctl == 3'b111 && !irq_accept_block)
    else $error("reset did not restore run");

  // Main scenarios reached
  c_hold: cover property (wake_evt.hold);
  c_nmi: cover property (wake_evt.ack && wake_evt.from_nmi);
  c_stop: cover property (clk_ctl == 3'b000);
  c_idle: cover property (clk_ctl == 3'b100);
endmodule

bind power_save_sequencer power_save_sequencer_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .halt_exec(halt_exec), .nmi_pin(nmi_pin), .irq_ctx(irq_ctx), .clk_ctl(clk_ctl),
  .irq_accept_block(irq_accept_block), .wake_evt(wake_evt));

//--- tb/power_save_sequencer_tb.sv
// Self-checking bench for the power-save sequencer.
// Drives the AXI4-Lite bus, halt pulses, NMI and interrupt context itself.
`timescale 1ns/1ps
`include "pss_cfg.svh"
module power_save_sequencer_tb;
  import pss_pkg::*;
  logic        aclk = 0, aresetn = 0, halt_exec = 0, nmi_pin = 0, en;
  axil_req_t   axil_req = '0;
  axil_rsp_t   axil_rsp;
  irq_ctx_t    irq_ctx = '0;
  irq_ctx_t    cx;
  int          exp_q[$];
  clk_ctl_t    clk_ctl;
  logic        irq_accept_block;
  wake_evt_t   wake_evt;
  int          error_cnt = 0, checked = 0, ctl_m = 0;
  logic [31:0] seed = 32'h47a8, rd_d;
  logic [1:0]  rs;

  power_save_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .halt_exec(halt_exec), .nmi_pin(nmi_pin), .irq_ctx(irq_ctx), .clk_ctl(clk_ctl),
    .irq_accept_block(irq_accept_block), .wake_evt(wake_evt));

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Rule model of a wake outcome, packed as {ack, branch, next_instr, hold, from_nmi}
  function automatic int wake_model(input int nmi, input irq_ctx_t c);
    int acc, br;
    acc = nmi ? !c.nmi_insvc : !c.nmi_insvc && (!c.insvc || c.mi_prio < c.insvc_prio);
    br = acc && (nmi || c.int_en);
    return 16 * acc + 8 * br + 4 * (acc - br) + 2 * (1 - acc) + nmi;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    axil_req.awaddr <= {24'h0, a};
    axil_req.wdata <= d;
    axil_req.wstrb <= 4'hf;
    axil_req.awvalid <= 1;
    axil_req.wvalid <= 1;
    axil_req.bready <= 1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (axil_rsp.awready) pa = 0;
      if (axil_rsp.wready) pw = 0;
      axil_req.awvalid <= pa;
      axil_req.wvalid <= pw;
    end
    do @(posedge aclk); while (!axil_rsp.bvalid);
    rs = axil_rsp.bresp;
    axil_req.bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    axil_req.araddr <= {24'h0, a};
    axil_req.arvalid <= 1;
    axil_req.rready <= 1;
    do @(posedge aclk); while (!axil_rsp.arready);
    axil_req.arvalid <= 0;
    do @(posedge aclk); while (!axil_rsp.rvalid);
    rd_d = axil_rsp.rdata;
    rs = axil_rsp.rresp;
    axil_req.rready <= 0;
    @(posedge aclk);
  endtask

  // Mode, then command, then control: control unlocks only as the next write after command
  task automatic prot(input logic [31:0] m, input logic [31:0] v);
    wr(`PSS_OFF_MODE, m);
    wr(`PSS_OFF_CMD, v);
    chk("block", irq_accept_block, 1);
    wr(`PSS_OFF_CTL, v);
  endtask

  task automatic halt();
    halt_exec <= 1;
    @(posedge aclk);
    halt_exec <= 0;
    repeat (2) @(posedge aclk);
    chk("halt clk", clk_ctl, 3'b110);
  endtask

  task automatic wake_w();
    do @(posedge aclk); while (wake_evt === '0);
  endtask

  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #40us;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(i * 4));
      chk("reset reg", rd_d, (i == 3) ? 32'h1 : 32'h0);
    end
    $display("test 1 done");
    // Control write without unlock is ignored and flagged
    wr(`PSS_OFF_CTL, 32'h30);
    rd(`PSS_OFF_CTL);
    chk("ctl locked", rd_d, 0);
    rd(`PSS_OFF_STAT);
    chk("perr", rd_d, 32'h9);
    wr(`PSS_OFF_STAT, 32'h8);
    rd(`PSS_OFF_STAT);
    chk("perr clr", rd_d, 32'h1);
    wr(8'h10, 32'h1);
    chk("unmapped", rs, `PSS_RESP_SLVERR);
    rd(8'h14);
    chk("unmapped rd", rd_d, 0);
    chk("rresp", rs, `PSS_RESP_SLVERR);
    ctl_m = rnd() & 32'h30;
    prot(0, ctl_m);
    chk("unblock", irq_accept_block, 0);
    rd(`PSS_OFF_CTL);
    chk("ctl", rd_d, ctl_m);
    $display("test 2 done");
    // Halt wake by maskable request across priority cases
    for (int i = 0; i < 4; i++)
    begin
      en = 1'(rnd());
      cx = {1'b0, 3'(2 * i), 1'(i > 0), 3'd3, 1'(i == 3), en};
      irq_ctx <= cx;
      exp_q.push_back(wake_model(0, cx));
      halt();
      irq_ctx.mi_req <= 1;
      wake_w();
      chk("wake", wake_evt, exp_q.pop_front());
      irq_ctx.mi_req <= 0;
      @(posedge aclk);
    end
    $display("test 3 done");
    // NMI wakes halt and is taken over the maskable handler in service
    cx = 10'h030;
    irq_ctx <= cx;
    exp_q.push_back(wake_model(1, cx));
    halt();
    nmi_pin <= 1;
    wake_w();
    chk("nmi wake", wake_evt, exp_q.pop_front());
    nmi_pin <= 0;
    $display("test 4 done");
    // Stop standby: maskable release disabled, NMI allowed
    prot(1, 32'h12);
    repeat (5) @(posedge aclk);
    chk("stop clk", clk_ctl, 3'b000);
    irq_ctx.mi_req <= 1;
    repeat (10) @(posedge aclk);
    chk("masked", clk_ctl, 3'b000);
    irq_ctx.mi_req <= 0;
    exp_q.push_back(wake_model(1, cx));
    nmi_pin <= 1;
    wake_w();
    chk("stop evt", wake_evt, exp_q.pop_front());
    @(posedge aclk);
    chk("stop wake", clk_ctl, 3'b111);
    nmi_pin <= 0;
    rd(`PSS_OFF_CTL);
    chk("stb clear", rd_d, 32'h10);
    $display("test 5 done");
    // Idle standby: NMI release disabled, maskable request wakes
    cx = {1'b0, 3'd1, 1'b1, 3'd3, 2'b00};
    irq_ctx <= cx;
    prot(0, 32'h22);
    repeat (5) @(posedge aclk);
    chk("idle clk", clk_ctl, 3'b100);
    nmi_pin <= 1;
    repeat (8) @(posedge aclk);
    chk("nmi masked", clk_ctl, 3'b100);
    exp_q.push_back(wake_model(0, cx));
    irq_ctx.mi_req <= 1;
    wake_w();
    chk("idle wake", wake_evt, exp_q.pop_front());
    irq_ctx.mi_req <= 0;
    nmi_pin <= 0;
    @(posedge aclk);
    chk("idle run", clk_ctl, 3'b111);
    rd(`PSS_OFF_CTL);
    chk("idle ctl", rd_d, 32'h20);
    $display("test 6 done");
    // Reset while halted acts as an ordinary reset
    halt();
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("reset clk", clk_ctl, 3'b111);
    rd(`PSS_OFF_CTL);
    chk("reset ctl", rd_d, 0);
    $display("test 7 done");
    end_sim();
  end
endmodule
